//--- common/ofcd_pkg.sv
// Constants and types shared by the option byte configuration decoder.
// Assumes a single 250 MHz clock domain and a separate power-on reset
// for the non-volatile byte store.
package ofcd_pkg;

    // ------------------------------------------------------------
    // Byte addresses and storage
    // ------------------------------------------------------------
    localparam int unsigned NUM_BYTES = 2;
    localparam logic [0:0] ADDR_BYTE0 = 1'h0;
    localparam logic [0:0] ADDR_BYTE1 = 1'h1;

    // ------------------------------------------------------------
    // Field positions, configuration byte 0
    // ------------------------------------------------------------
    localparam int unsigned B0_RSVD_MSB = 7;
    localparam int unsigned B0_RSVD_LSB = 4;
    localparam int unsigned B0_SIZE_MSB = 3;
    localparam int unsigned B0_SIZE_LSB = 2;
    localparam int unsigned B0_READOUT = 1;
    localparam int unsigned B0_WRPROT = 0;

    // ------------------------------------------------------------
    // Field positions, configuration byte 1
    // ------------------------------------------------------------
    localparam int unsigned B1_PLL_X8 = 7;
    localparam int unsigned B1_PLL_BYP = 6;
    localparam int unsigned B1_RSVD = 5;
    localparam int unsigned B1_RC_OFF = 4;
    localparam int unsigned B1_LVD_MSB = 3;
    localparam int unsigned B1_LVD_LSB = 2;
    localparam int unsigned B1_WDT_SOFT = 1;
    localparam int unsigned B1_WDT_HALT = 0;

    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [7:0] FACTORY_BYTE0 = 8'hfc;
    localparam logic [7:0] FACTORY_BYTE1 = 8'hef;
    localparam logic [7:0] RDATA_IDLE = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OFCD_CMD_READ = 2'h0,
        OFCD_CMD_WRITE = 2'h1,
        OFCD_CMD_ERASE = 2'h2
    } ofcd_cmd_t;

    typedef enum logic [1:0] {
        OFCD_SECTOR_0K5 = 2'h0,
        OFCD_SECTOR_1K = 2'h1,
        OFCD_SECTOR_1K5 = 2'h2
    } ofcd_sector_t;

    typedef enum logic [1:0] {
        OFCD_LVD_LOW = 2'h0,
        OFCD_LVD_MED = 2'h1,
        OFCD_LVD_HIGH = 2'h2,
        OFCD_LVD_OFF = 2'h3
    } ofcd_lvd_t;

    // Gray codes along load0 -> load1 -> latch -> run -> erase
    typedef enum logic [2:0] {
        OFCD_PH_LOAD0 = 3'h0,
        OFCD_PH_LOAD1 = 3'h1,
        OFCD_PH_LATCH = 3'h3,
        OFCD_PH_RUN = 3'h2,
        OFCD_PH_ERASE = 3'h6
    } ofcd_state_t;

    typedef struct packed {
        ofcd_cmd_t cmd;
        logic [0:0] addr;
        logic [7:0] wdata;
    } ofcd_req_t;

    typedef struct packed {
        ofcd_sector_t sector0_size_sel;
        logic readout_protect;
        logic flash_write_protect;
        logic pll_factor_sel;
        logic pll_bypass;
        logic rc_osc_disable;
        logic lvd_enable;
        ofcd_lvd_t low_voltage_thresh_sel;
        logic watchdog_type_sel;
        logic watchdog_halt_reset;
    } ofcd_cfg_t;

    localparam ofcd_cfg_t CFG_RESET = '0;

endpackage

//--- core/ofcd_nv_store.sv
// Two-byte non-volatile configuration store with registered read data.
// Assumes nv_init_n is a power-on reset only; rst_n of the device does not
// touch the stored bytes, so programmed values survive a device reset.
module ofcd_nv_store (
    input wire logic sys_clk,
    input wire logic nv_init_n,
    input wire logic rd_en,
    input wire logic [0:0] rd_addr,
    input wire logic wr_en,
    input wire logic [0:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic clear_all,
    output logic [7:0] rd_data
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] mem [ofcd_pkg::NUM_BYTES];

    // Parts leave the factory with the RC oscillator selected
    always_ff @(posedge sys_clk or negedge nv_init_n) begin
        if (!nv_init_n) begin
            mem[0] <= ofcd_pkg::FACTORY_BYTE0; // [R12]
            mem[1] <= ofcd_pkg::FACTORY_BYTE1; // [R12]
        end else if (clear_all) begin
            mem[0] <= ofcd_pkg::FACTORY_BYTE0;
            mem[1] <= ofcd_pkg::FACTORY_BYTE1;
        end else if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nv_init_n) begin
        if (!nv_init_n) begin
            rd_data <= ofcd_pkg::RDATA_IDLE;
        end else if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

//--- core/ofcd_option_byte_config_decode.sv
// Option byte configuration decoder: holds two configuration bytes,
// loads and decodes them after each reset, and serves a programming port.
// Assumes a flash controller that honours the block outputs and performs
// the mass erase when asked.
//
// Notes on behaviour
// [R1] Programmer writes ones into byte 0 bits 7:4.
// [R2] Sector 0 size: 00 gives 0.5k, 01 gives 1k, 1x gives 1.5k.
// [R3] Readout protect set blocks memory extraction and flash writes.
// [R4] Erasing option bytes under readout protect erases whole memory first.
// [R5] Write protect set refuses flash and protect-bit erase or programming.
// [R6] Byte 1 bit 7 picks PLL multiply by four or eight.
// [R7] Byte 1 bit 6 zero enables PLL, one bypasses it.
// [R8] Byte 1 bit 4 zero runs RC oscillator, one uses external clock.
// [R9] Programmer writes one into byte 1 bit 5.
// [R10] Byte 1 bits 3:2 enable low-voltage detector and choose threshold.
// [R11] Option bytes are read or written only in programming mode.
// [R12] Factory state: memory erased, RC oscillator selected.
// [R13] Detector field: 11 off, 10 high, 01 medium, 00 low.
// [R14] Byte 1 bit 1: zero hardware watchdog, one software-enabled.
// [R15] Byte 1 bit 0 one: reset on halt with watchdog active.
// [R16] Bytes read during reset; settings stay fixed until next reset.
module ofcd_option_byte_config_decode (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic nv_init_n,
    input wire logic prog_mode,
    input wire logic prog_req,
    input wire ofcd_pkg::ofcd_req_t prog_cmd,
    input wire logic mass_erase_done,
    output ofcd_pkg::ofcd_cfg_t cfg,
    output logic cfg_valid,
    output logic flash_read_block,
    output logic flash_write_block,
    output logic mass_erase_req,
    output logic prog_busy,
    output logic prog_ack,
    output logic prog_err,
    output logic [7:0] prog_rdata
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic ofcd_pkg::ofcd_sector_t sector_of(input logic [1:0] f);
        if (f[1]) begin
            return ofcd_pkg::OFCD_SECTOR_1K5; // [R2]
        end else if (f[0]) begin
            return ofcd_pkg::OFCD_SECTOR_1K; // [R2]
        end else begin
            return ofcd_pkg::OFCD_SECTOR_0K5; // [R2]
        end
    endfunction

    // Reserved bits are not looked at; the programmer keeps them at one
    function automatic ofcd_pkg::ofcd_cfg_t decode(input logic [7:0] b0,
                                                   input logic [7:0] b1);
        ofcd_pkg::ofcd_cfg_t c;
        logic [1:0] lvd;
        c = ofcd_pkg::CFG_RESET;
        lvd = b1[ofcd_pkg::B1_LVD_MSB:ofcd_pkg::B1_LVD_LSB];
        c.sector0_size_sel =
            sector_of(b0[ofcd_pkg::B0_SIZE_MSB:ofcd_pkg::B0_SIZE_LSB]); // [R2] [R1]
        c.readout_protect = b0[ofcd_pkg::B0_READOUT]; // [R3]
        c.flash_write_protect = b0[ofcd_pkg::B0_WRPROT]; // [R5]
        c.pll_factor_sel = b1[ofcd_pkg::B1_PLL_X8]; // [R6]
        c.pll_bypass = b1[ofcd_pkg::B1_PLL_BYP]; // [R7] [R9]
        c.rc_osc_disable = b1[ofcd_pkg::B1_RC_OFF]; // [R8]
        c.low_voltage_thresh_sel = ofcd_pkg::ofcd_lvd_t'(lvd); // [R13]
        c.lvd_enable = (lvd != 2'h3); // [R10] [R13]
        c.watchdog_type_sel = b1[ofcd_pkg::B1_WDT_SOFT]; // [R14]
        c.watchdog_halt_reset = b1[ofcd_pkg::B1_WDT_HALT]; // [R15]
        return c;
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ofcd_pkg::ofcd_state_t state;
    ofcd_pkg::ofcd_state_t next_state;
    logic [7:0] cap_byte0;
    logic live_readout;
    logic live_wrprot;
    logic [7:0] store_rdata;
    logic store_rd_en;
    logic [0:0] store_rd_addr;
    logic store_wr_en;
    logic store_clear;
    logic take;
    logic cmd_rd;
    logic cmd_wr;
    logic cmd_erase;
    logic refuse;
    logic erase_now;
    logic erase_wait;
    logic ans_valid;
    logic ans_err;
    logic ans_rd;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    // Requests are only seen while idle in run; busy periods drop them
    assign take = prog_req && (state == ofcd_pkg::OFCD_PH_RUN);
    assign cmd_rd = (prog_cmd.cmd == ofcd_pkg::OFCD_CMD_READ);
    assign cmd_wr = (prog_cmd.cmd == ofcd_pkg::OFCD_CMD_WRITE);
    assign cmd_erase = (prog_cmd.cmd == ofcd_pkg::OFCD_CMD_ERASE);

    always_comb begin
        refuse = 1'b0;
        if (!prog_mode) begin
            refuse = 1'b1; // [R11]
        end else if (!(cmd_rd || cmd_wr || cmd_erase)) begin
            refuse = 1'b1;
        end else if (live_wrprot && cmd_erase) begin
            refuse = 1'b1; // [R5]
        end else if (live_wrprot && cmd_wr &&
                     prog_cmd.addr == ofcd_pkg::ADDR_BYTE0) begin
            refuse = 1'b1; // [R5]
        end
    end

    // Erase goes straight through unless readout protect demands a wipe
    assign erase_now = take && !refuse && cmd_erase && !live_readout;
    assign erase_wait = take && !refuse && cmd_erase && live_readout; // [R4]

    // ------------------------------------------------------------
    // Store access
    // ------------------------------------------------------------
    always_comb begin
        store_rd_en = 1'b0;
        store_rd_addr = ofcd_pkg::ADDR_BYTE0;
        case (state)
            ofcd_pkg::OFCD_PH_LOAD0: begin
                store_rd_en = 1'b1; // [R16]
                store_rd_addr = ofcd_pkg::ADDR_BYTE0;
            end
            ofcd_pkg::OFCD_PH_LOAD1: begin
                store_rd_en = 1'b1; // [R16]
                store_rd_addr = ofcd_pkg::ADDR_BYTE1;
            end
            ofcd_pkg::OFCD_PH_RUN: begin
                store_rd_en = take && !refuse && cmd_rd; // [R11]
                store_rd_addr = prog_cmd.addr;
            end
            default: begin
                store_rd_en = 1'b0;
                store_rd_addr = ofcd_pkg::ADDR_BYTE0;
            end
        endcase
    end

    assign store_wr_en = take && !refuse && cmd_wr; // [R11] [R5]
    assign store_clear = erase_now ||
                         (state == ofcd_pkg::OFCD_PH_ERASE && mass_erase_done); // [R4]

    ofcd_nv_store u_store (
        .sys_clk(sys_clk),
        .nv_init_n(nv_init_n),
        .rd_en(store_rd_en),
        .rd_addr(store_rd_addr),
        .wr_en(store_wr_en),
        .wr_addr(prog_cmd.addr),
        .wr_data(prog_cmd.wdata),
        .clear_all(store_clear),
        .rd_data(store_rdata)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ofcd_pkg::OFCD_PH_LOAD0: next_state = ofcd_pkg::OFCD_PH_LOAD1;
            ofcd_pkg::OFCD_PH_LOAD1: next_state = ofcd_pkg::OFCD_PH_LATCH;
            ofcd_pkg::OFCD_PH_LATCH: next_state = ofcd_pkg::OFCD_PH_RUN;
            ofcd_pkg::OFCD_PH_RUN: begin
                if (erase_wait) begin
                    next_state = ofcd_pkg::OFCD_PH_ERASE; // [R4]
                end
            end
            ofcd_pkg::OFCD_PH_ERASE: begin
                if (mass_erase_done) begin
                    next_state = ofcd_pkg::OFCD_PH_RUN;
                end
            end
            default: next_state = ofcd_pkg::OFCD_PH_LOAD0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ofcd_pkg::OFCD_PH_LOAD0;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_busy <= 1'b1;
        end else begin
            prog_busy <= (next_state != ofcd_pkg::OFCD_PH_RUN);
        end
    end

    // ------------------------------------------------------------
    // Load and decode
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_byte0 <= 8'h00;
        end else if (state == ofcd_pkg::OFCD_PH_LOAD1) begin
            cap_byte0 <= store_rdata; // [R16]
        end
    end

    // Decoded settings change only here, once per reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= ofcd_pkg::CFG_RESET;
            cfg_valid <= 1'b0;
        end else if (state == ofcd_pkg::OFCD_PH_LATCH) begin
            cfg <= decode(cap_byte0, store_rdata); // [R16]
            cfg_valid <= 1'b1; // [R16]
        end
    end

    // Until the bytes are loaded the flash stays fully blocked
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_read_block <= 1'b1;
            flash_write_block <= 1'b1;
        end else if (state == ofcd_pkg::OFCD_PH_LATCH) begin
            flash_read_block <= cap_byte0[ofcd_pkg::B0_READOUT]; // [R3]
            flash_write_block <= cap_byte0[ofcd_pkg::B0_READOUT] ||
                                 cap_byte0[ofcd_pkg::B0_WRPROT]; // [R3] [R5]
        end
    end

    // ------------------------------------------------------------
    // Live protection state for the programming port
    // ------------------------------------------------------------
    // Tracks the stored byte 0 so refusals follow writes before any reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            live_readout <= 1'b1;
            live_wrprot <= 1'b1;
        end else if (state == ofcd_pkg::OFCD_PH_LOAD1) begin
            live_readout <= store_rdata[ofcd_pkg::B0_READOUT];
            live_wrprot <= store_rdata[ofcd_pkg::B0_WRPROT];
        end else if (store_clear) begin
            live_readout <= ofcd_pkg::FACTORY_BYTE0[ofcd_pkg::B0_READOUT];
            live_wrprot <= ofcd_pkg::FACTORY_BYTE0[ofcd_pkg::B0_WRPROT];
        end else if (store_wr_en && prog_cmd.addr == ofcd_pkg::ADDR_BYTE0) begin
            live_readout <= prog_cmd.wdata[ofcd_pkg::B0_READOUT];
            live_wrprot <= prog_cmd.wdata[ofcd_pkg::B0_WRPROT]; // [R5]
        end
    end

    // ------------------------------------------------------------
    // Mass erase handshake
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mass_erase_req <= 1'b0;
        end else if (erase_wait) begin
            mass_erase_req <= 1'b1; // [R4]
        end else if (state == ofcd_pkg::OFCD_PH_ERASE && mass_erase_done) begin
            mass_erase_req <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Answer pipeline
    // ------------------------------------------------------------
    // Two stages so read data and refusals answer with the same latency
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ans_valid <= 1'b0;
            ans_err <= 1'b0;
            ans_rd <= 1'b0;
        end else begin
            ans_valid <= (take && !erase_wait) ||
                         (state == ofcd_pkg::OFCD_PH_ERASE && mass_erase_done);
            ans_err <= take && refuse; // [R11]
            ans_rd <= take && !refuse && cmd_rd;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_ack <= 1'b0;
            prog_err <= 1'b0;
            prog_rdata <= ofcd_pkg::RDATA_IDLE;
        end else begin
            prog_ack <= ans_valid;
            prog_err <= ans_valid && ans_err;
            if (ans_valid && ans_rd) begin
                prog_rdata <= store_rdata; // [R11]
            end else begin
                prog_rdata <= ofcd_pkg::RDATA_IDLE;
            end
        end
    end

endmodule

//--- verif/ofcd_option_byte_config_decode_checker.sv
// Concurrent checks on the option byte decoder's top-level ports.
// Assumes the single sys_clk domain with rst_n asynchronous, active low.
module ofcd_option_byte_config_decode_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic nv_init_n,
    input wire logic prog_mode,
    input wire logic prog_req,
    input wire ofcd_pkg::ofcd_req_t prog_cmd,
    input wire logic mass_erase_done,
    input wire ofcd_pkg::ofcd_cfg_t cfg,
    input wire logic cfg_valid,
    input wire logic flash_read_block,
    input wire logic flash_write_block,
    input wire logic mass_erase_req,
    input wire logic prog_busy,
    input wire logic prog_ack,
    input wire logic prog_err,
    input wire logic [7:0] prog_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_rw_ack;
        prog_req && !prog_busy && prog_mode && !prog_cmd.cmd[1] |-> ##2 prog_ack;
    endproperty
    a_rw_ack: assert property (p_rw_ack) else $error("read or write answer late");
    property p_no_mode;
        prog_req && !prog_busy && !prog_mode |-> ##2 (prog_ack && prog_err);
    endproperty
    a_no_mode: assert property (p_no_mode) else $error("access outside mode taken");
    property p_err_ack;
        prog_err |-> prog_ack;
    endproperty
    a_err_ack: assert property (p_err_ack) else $error("error without answer");
    property p_rdata_idle;
        !prog_ack |-> prog_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_cfg_hold;
        cfg_valid |=> cfg_valid && $stable(cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("settings moved");
    property p_blocks;
        cfg_valid |-> flash_read_block == cfg.readout_protect
            && flash_write_block == (cfg.readout_protect | cfg.flash_write_protect);
    endproperty
    a_blocks: assert property (p_blocks) else $error("block outputs wrong");
    property p_pre_load;
        !cfg_valid |-> flash_read_block && flash_write_block && prog_busy;
    endproperty
    a_pre_load: assert property (p_pre_load) else $error("open before load");
    property p_lvd;
        cfg_valid |-> cfg.lvd_enable
            == (cfg.low_voltage_thresh_sel != ofcd_pkg::OFCD_LVD_OFF);
    endproperty
    a_lvd: assert property (p_lvd) else $error("detector enable wrong");
    property p_erase_end;
        mass_erase_req && mass_erase_done |-> ##1 (!mass_erase_req && !prog_busy) ##1 prog_ack;
    endproperty
    a_erase_end: assert property (p_erase_end) else $error("erase end wrong");
    property p_erase_busy;
        mass_erase_req |-> prog_busy;
    endproperty
    a_erase_busy: assert property (p_erase_busy) else $error("idle during erase");
endmodule

bind ofcd_option_byte_config_decode ofcd_option_byte_config_decode_checker u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .nv_init_n(nv_init_n), .prog_mode(prog_mode),
    .prog_req(prog_req), .prog_cmd(prog_cmd), .mass_erase_done(mass_erase_done),
    .cfg(cfg), .cfg_valid(cfg_valid), .flash_read_block(flash_read_block),
    .flash_write_block(flash_write_block), .mass_erase_req(mass_erase_req),
    .prog_busy(prog_busy), .prog_ack(prog_ack), .prog_err(prog_err),
    .prog_rdata(prog_rdata)
);

//--- verif/ofcd_prog_tool.sv
// Programming tool stand-in driving the programming port.
// Assumes the bench calls op() and the port samples on the rising edge.
module ofcd_prog_tool (
    input wire logic sys_clk,
    input wire logic prog_busy,
    input wire logic prog_ack,
    input wire logic prog_err,
    input wire logic [7:0] prog_rdata,
    output logic prog_mode,
    output logic prog_req,
    output ofcd_pkg::ofcd_req_t prog_cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    int n;

    initial begin
        prog_mode = 1'b0;
        prog_req = 1'b0;
        prog_cmd = '0;
    end

    task automatic op(input logic md, input logic [1:0] cmd, input logic ad,
            input logic [7:0] wd, output logic err, output logic [7:0] rd);
        @(negedge sys_clk);
        prog_mode = md;
        for (n = 0; n < 300 && prog_busy !== 1'b0; n++) @(negedge sys_clk);
        @(negedge sys_clk);
        prog_req = 1'b1;
        prog_cmd.cmd = ofcd_pkg::ofcd_cmd_t'(cmd);
        prog_cmd.addr = ad;
        // Reserved positions go out as ones on writes
        prog_cmd.wdata = wd | (cmd == 2'h1 ? (ad ? 8'h20 : 8'hf0) : 8'h00);
        @(negedge sys_clk);
        prog_req = 1'b0;
        // Released lines flip so a stale command never matches the one just sent
        prog_cmd = ofcd_pkg::ofcd_req_t'(~prog_cmd);
        for (n = 0; n < 300 && prog_ack !== 1'b1; n++) @(negedge sys_clk);
        err = (n == 300) ? 1'bx : prog_err;
        rd = prog_rdata;
        prog_mode = 1'b0;
    endtask
endmodule

//--- verif/option_byte_config_decode_tb_top.sv
// Self-checking bench for the option byte decoder.
// Assumes the tool model in ofcd_prog_tool and a flash stand-in here.
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin err_count++; \
    $display("unexpected %s exp %h got %h", nm, e, a); end end
module option_byte_config_decode_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] b0;
        logic [7:0] b1;
        logic [11:0] cfg;
        logic [1:0] blk;
    } ofcd_row_t;
    // cfg column: size, ro, wp, x8, byp, rc_off, lvd_en, lvd, wdt_type, halt_rst
    ofcd_row_t rows [4] = '{'{8'hf0, 8'h20, 12'h010, 2'h0}, '{8'hf4, 8'ha5, 12'h495, 2'h0},
        '{8'hf8, 8'h7a, 12'h87a, 2'h0}, '{8'hfe, 8'hef, 12'hacf, 2'h3}};
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic nv_init_n = 1'b0;
    logic mass_erase_done = 1'b0;
    logic prog_mode, prog_req, cfg_valid, flash_read_block, flash_write_block;
    logic mass_erase_req, prog_busy, prog_ack, prog_err;
    logic [7:0] prog_rdata;
    ofcd_pkg::ofcd_req_t prog_cmd;
    ofcd_pkg::ofcd_cfg_t cfg;
    int err_count = 0;
    int checks = 0;
    int mcnt = 0;
    int erase_seen = 0;

    always #2 sys_clk = ~sys_clk;

    ofcd_option_byte_config_decode dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .nv_init_n(nv_init_n), .prog_mode(prog_mode), .prog_req(prog_req),
        .prog_cmd(prog_cmd), .mass_erase_done(mass_erase_done), .cfg(cfg),
        .cfg_valid(cfg_valid), .flash_read_block(flash_read_block),
        .flash_write_block(flash_write_block), .mass_erase_req(mass_erase_req),
        .prog_busy(prog_busy), .prog_ack(prog_ack), .prog_err(prog_err),
        .prog_rdata(prog_rdata));
    ofcd_prog_tool u_tool (.sys_clk(sys_clk), .prog_busy(prog_busy), .prog_ack(prog_ack),
        .prog_err(prog_err), .prog_rdata(prog_rdata), .prog_mode(prog_mode),
        .prog_req(prog_req), .prog_cmd(prog_cmd));

    // Flash controller stand-in: finishes a mass erase after a few cycles
    always @(negedge sys_clk) begin
        if (mass_erase_req) mcnt++;
        else mcnt = 0;
        if (mass_erase_req && mcnt == 1) erase_seen++;
        mass_erase_done <= (mcnt == 6);
    end

    task automatic conclude();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic dev_reset(input logic por);
        @(negedge sys_clk);
        rst_n = 1'b0;
        nv_init_n = ~por;
        repeat (5) @(negedge sys_clk);
        `CHK("in reset", {cfg, cfg_valid}, 13'h0000)
        `CHK("in reset blocks", {flash_read_block, flash_write_block, prog_busy}, 3'h7)
        rst_n = 1'b1;
        nv_init_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        `CHK("early valid", 1'b0, cfg_valid)
        @(negedge sys_clk);
        `CHK("valid", 1'b1, cfg_valid)
    endtask

    task automatic rw(input logic md, input logic [1:0] cmd, input logic ad,
            input logic [7:0] wd, input logic ee, input logic [7:0] er);
        logic e;
        logic [7:0] r;
        u_tool.op(md, cmd, ad, wd, e, r);
        `CHK("refusal", ee, e)
        `CHK("rdata", er, r)
    endtask

    initial begin
        dev_reset(1'b1);
        `CHK("factory", {cfg, flash_read_block, flash_write_block}, {12'h8cf, 2'h0})
        rw(1'b1, 2'h0, 1'b1, 8'h00, 1'b0, 8'hef);
        foreach (rows[i]) begin
            rw(1'b1, 2'h1, 1'b0, rows[i].b0, 1'b0, 8'h00);
            rw(1'b1, 2'h1, 1'b1, rows[i].b1, 1'b0, 8'h00);
            rw(1'b1, 2'h0, 1'b0, 8'h00, 1'b0, rows[i].b0);
            dev_reset(1'b0);
            `CHK("cfg", rows[i].cfg, cfg)
            `CHK("blocks", rows[i].blk, {flash_read_block, flash_write_block})
        end
        // Late writes must not reach the loaded settings
        rw(1'b1, 2'h1, 1'b1, 8'h00, 1'b0, 8'h00);
        repeat (4) @(negedge sys_clk);
        `CHK("held cfg", 12'hacf, cfg)
        rw(1'b0, 2'h0, 1'b0, 8'h00, 1'b1, 8'h00);
        rw(1'b1, 2'h3, 1'b0, 8'h00, 1'b1, 8'h00);
        rw(1'b1, 2'h2, 1'b0, 8'h00, 1'b0, 8'h00);
        `CHK("mass erase", 1, erase_seen)
        rw(1'b1, 2'h0, 1'b0, 8'h00, 1'b0, 8'hfc);
        rw(1'b1, 2'h2, 1'b0, 8'h00, 1'b0, 8'h00);
        `CHK("no mass erase", 1, erase_seen)
        rw(1'b1, 2'h1, 1'b0, 8'h01, 1'b0, 8'h00);
        rw(1'b1, 2'h1, 1'b0, 8'h00, 1'b1, 8'h00);
        rw(1'b1, 2'h2, 1'b0, 8'h00, 1'b1, 8'h00);
        rw(1'b1, 2'h0, 1'b0, 8'h00, 1'b0, 8'hf1);
        rw(1'b1, 2'h1, 1'b1, 8'h00, 1'b0, 8'h00);
        dev_reset(1'b0);
        `CHK("wp cfg", 12'h110, cfg)
        `CHK("wp blocks", 2'h1, {flash_read_block, flash_write_block})
        conclude();
    end

    initial begin
        #100us;
        err_count++;
        conclude();
    end
endmodule
